// ==== lpen_pkg.sv ====
// constants for the pen latch and pot port
package lpen_pkg;
  localparam logic [23:0] pot_read_addr = 24'hDFF016;
  localparam logic [23:0] pot_write_addr = 24'hDFF034;
  localparam logic [23:0] beam_upper_addr = 24'hDFF004;
  localparam logic [23:0] beam_lower_addr = 24'hDFF006;
  localparam logic [23:0] plane_ctl_addr = 24'hDFF100;
  localparam logic [23:0] pot0_addr = 24'hDFF012;
  localparam logic [23:0] pot1_addr = 24'hDFF014;
  localparam logic [23:0] line_ctl_addr = 24'hDFF1F0;
  localparam int pen_enable_bit = 3;
  localparam int interlace_bit = 2;
  localparam int start_bit = 0;
  localparam int pin_field_lo = 8;
  localparam int long_frame_bit = 15;
  localparam int num_pins = 4;
  localparam logic [8:0] vblank_end_line = 9'h014;
  localparam logic [8:0] default_lines = 9'h106;
  localparam logic [8:0] default_width = 9'h0E3;
  localparam logic [3:0] pot_hold_lines = 4'h7;
  localparam logic [15:0] ident_bits = 16'h0000; // arbitrary value
endpackage

// ==== beam_if.sv ====
// live beam counter signals passed from counter to top
`timescale 1ns/100ps
interface beam_if;
  logic [8:0] vpos;
  logic [8:0] hpos;
  logic long_frame;
  logic line_start;
  logic vblank_exit;
  modport src (output vpos, hpos, long_frame, line_start, vblank_exit);
  modport dst (input vpos, hpos, long_frame, line_start, vblank_exit);
endinterface

// ==== beam_counter.sv ====
// free running horizontal and vertical beam counter
`timescale 1ns/100ps
module beam_counter
  import lpen_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_reset, // sync reset
  input wire logic [8:0] i_last_h, // last horizontal count
  input wire logic [8:0] i_last_v, // last line of short frame
  input wire logic i_interlace, // toggle long frame each frame
  beam_if.src b // live beam
);
  logic [8:0] next_h;
  logic [8:0] next_v;
  logic next_lf;
  logic [8:0] frame_end;
  always_comb begin
    frame_end = i_last_v + {8'h00, b.long_frame};
    next_h = b.hpos + 9'h001;
    next_v = b.vpos;
    next_lf = b.long_frame;
    if (b.hpos >= i_last_h) begin
      next_h = 9'h000;
      next_v = b.vpos + 9'h001;
      if (b.vpos >= frame_end) begin
        next_v = 9'h000;
        next_lf = i_interlace ? ~b.long_frame : 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      b.hpos <= 9'h000;
      b.vpos <= 9'h000;
      b.long_frame <= 1'b0;
      b.line_start <= 1'b0;
      b.vblank_exit <= 1'b0;
    end else begin
      b.hpos <= next_h;
      b.vpos <= next_v;
      b.long_frame <= next_lf;
      b.line_start <= (next_h == 9'h000);
      b.vblank_exit <= (next_h == 9'h000) && (next_v == vblank_end_line);
    end
  end
endmodule

// ==== lightpen_pot_port.sv ====
// pen beam latch and pot i/o port
`timescale 1ns/100ps
module lightpen_pot_port
  import lpen_pkg::*;
#(
  parameter logic [8:0] p_last_v = default_lines, // short frame last line
  parameter logic [8:0] p_last_h = default_width // last horizontal count
)(
  input wire logic i_clk, // 10 MHz clock
  input wire logic i_reset, // sync reset, high
  input wire logic [23:0] i_addr, // register byte address
  input wire logic [15:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [15:0] o_rdata, // read data, cycle after strobe
  input wire logic i_fire_n, // port 0 fire pin, pen trigger
  input wire logic [num_pins-1:0] i_pot_pin, // pot pin levels
  input wire logic [num_pins-1:0] i_pot_cmp, // cap above threshold
  output logic [num_pins-1:0] o_pot_pin, // pot pin drive level
  output logic [num_pins-1:0] o_pot_oe, // pot pin drive enable
  output logic [num_pins-1:0] o_pot_dump // discharge capacitors
);
  import lpen_pkg::*;
  beam_if beam();
  logic [15:0] plane_ctl;
  logic [8:0] line_ctl;
  logic [7:0] pot_ctl;
  logic frozen;
  logic [15:0] hold_upper;
  logic [15:0] hold_lower;
  logic [1:0] fire_sync;
  logic fire_prev;
  logic [num_pins-1:0] pin_m;
  logic [num_pins-1:0] pin_s;
  logic [num_pins-1:0] cmp_m;
  logic [num_pins-1:0] cmp_s;
  logic [7:0] pot_cnt [num_pins];
  logic [num_pins-1:0] pot_done;
  logic [3:0] reset_lines;
  logic dumping;
  logic [15:0] next_rdata;
  logic [15:0] live_upper;
  logic [15:0] live_lower;
  logic next_frozen;
  logic pen_edge;
  logic pot_go;

  beam_counter u_beam (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_last_h(p_last_h),
    .i_last_v(p_last_v),
    .i_interlace(plane_ctl[interlace_bit]),
    .b(beam.src)
  );

  // beam value formatting
  always_comb begin
    live_upper = '0;
    live_upper[long_frame_bit] = beam.long_frame;
    live_upper[0] = beam.vpos[8];
    live_lower = {beam.vpos[7:0], beam.hpos[8:1]};
  end

  // synchronisers for pins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fire_sync <= 2'b11;
      fire_prev <= 1'b1;
      pin_m <= '0;
      pin_s <= '0;
      cmp_m <= '0;
      cmp_s <= '0;
    end else begin
      fire_sync <= {fire_sync[0], i_fire_n};
      fire_prev <= fire_sync[1];
      pin_m <= i_pot_pin;
      pin_s <= pin_m;
      cmp_m <= i_pot_cmp;
      cmp_s <= cmp_m;
    end
  end

  assign pen_edge = fire_prev && !fire_sync[1];

  // pen capture
  always_comb begin
    next_frozen = frozen;
    if (beam.vblank_exit) begin
      next_frozen = 1'b0;
    end else if (!frozen && pen_edge && plane_ctl[pen_enable_bit]) begin
      next_frozen = 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      frozen <= 1'b0;
      hold_upper <= '0;
      hold_lower <= '0;
    end else begin
      frozen <= next_frozen;
      if (next_frozen && !frozen) begin
        hold_upper <= live_upper;
        hold_lower <= live_lower;
      end
    end
  end

  // registers
  assign pot_go = i_wr && (i_addr == pot_write_addr) && i_wdata[start_bit];
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      plane_ctl <= '0;
      line_ctl <= p_last_v;
      pot_ctl <= '0;
    end else if (i_wr) begin
      if (i_addr == plane_ctl_addr) begin
        plane_ctl <= i_wdata;
      end
      if (i_addr == pot_write_addr) begin
        pot_ctl <= i_wdata[15:pin_field_lo];
      end
      if (i_addr == line_ctl_addr) begin
        line_ctl <= i_wdata[8:0];
      end
    end
  end

  // pin drive, enable above data in each pair
  for (genvar i = 0; i < num_pins; i++) begin : g_pin
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        o_pot_oe[i] <= 1'b0;
        o_pot_pin[i] <= 1'b0;
        o_pot_dump[i] <= 1'b0;
      end else begin
        o_pot_oe[i] <= pot_ctl[2*i+1];
        o_pot_pin[i] <= pot_ctl[2*i];
        o_pot_dump[i] <= dumping && !pot_ctl[2*i+1];
      end
    end
    always_ff @(posedge i_clk) begin
      if (i_reset || pot_go) begin
        pot_cnt[i] <= 8'h00;
        pot_done[i] <= 1'b0;
      end else if (beam.line_start && !dumping && !pot_done[i]
                   && !pot_ctl[2*i+1]) begin
        if (cmp_s[i]) begin
          pot_done[i] <= 1'b1;
        end else begin
          pot_cnt[i] <= pot_cnt[i] + 8'h01;
        end
      end
    end
  end

  // pot reset interval counted in lines
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      reset_lines <= 4'h0;
      dumping <= 1'b0;
    end else if (pot_go) begin
      reset_lines <= 4'h0;
      dumping <= 1'b1;
    end else if (dumping && beam.line_start) begin
      reset_lines <= reset_lines + 4'h1;
      if (reset_lines == pot_hold_lines) begin
        dumping <= 1'b0;
      end
    end
  end

  // read mux; pin order matches control layout
  always_comb begin
    next_rdata = 16'h0000;
    case (i_addr)
      beam_upper_addr: next_rdata = frozen ? hold_upper : live_upper;
      beam_lower_addr: next_rdata = frozen ? hold_lower : live_lower;
      pot_read_addr: begin
        next_rdata = ident_bits;
        for (int k = 0; k < num_pins; k++) begin
          next_rdata[pin_field_lo+2*k+1] = pot_ctl[2*k+1];
          next_rdata[pin_field_lo+2*k] = pin_s[k];
        end
      end
      pot0_addr: next_rdata = {pot_cnt[1], pot_cnt[0]};
      pot1_addr: next_rdata = {pot_cnt[3], pot_cnt[2]};
      plane_ctl_addr: next_rdata = plane_ctl;
      line_ctl_addr: next_rdata = {7'h00, line_ctl};
      default: next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? next_rdata : 16'h0000;
    end
  end

  // checks
  release_at_line_a: assert property (@(posedge i_clk) disable iff (i_reset)
    beam.vblank_exit |=> !frozen)
    else $error("freeze not released at line 20");
  pen_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !frozen && !plane_ctl[pen_enable_bit] && !beam.vblank_exit
    |=> !frozen)
    else $error("pen captured while disabled");
  hold_stable_a: assert property (@(posedge i_clk) disable iff (i_reset)
    frozen && $past(frozen) |-> $stable(hold_lower))
    else $error("held position changed");
  pen_capture_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !frozen && pen_edge && plane_ctl[pen_enable_bit] && !beam.vblank_exit
    |=> frozen && hold_lower == $past(live_lower))
    else $error("capture missed");
  counter_runs_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    frozen && beam.hpos != p_last_h |=> beam.hpos == $past(beam.hpos) + 9'h001)
    else $error("counter stopped while frozen");
  pot_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    pot_go |=> pot_cnt[0] == 8'h00 && dumping)
    else $error("start did not clear counts");
  pin_drive_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_wr && i_addr == pot_write_addr
    |=> ##1 o_pot_oe[3] == $past(i_wdata[15], 2))
    else $error("right y enable wrong");
  dump_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    dumping |-> pot_cnt[1] == 8'h00)
    else $error("count moved during reset interval");
  read_data_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  cover_capture: cover property (@(posedge i_clk) !frozen ##1 frozen);
  cover_release: cover property (@(posedge i_clk) frozen ##1 !frozen);
  cover_start: cover property (@(posedge i_clk) pot_go);
  cover_button: cover property (@(posedge i_clk)
    o_pot_oe[0] && o_pot_pin[0] && !pin_s[0]);
  cover_count_done: cover property (@(posedge i_clk)
    !pot_done[2] ##1 pot_done[2]);

  // read formatting of the beam position
  upper_format_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == beam_upper_addr && !frozen
    |=> o_rdata == {$past(beam.long_frame), 14'h0000, $past(beam.vpos[8])})
    else $error("upper beam read badly formatted");
  lower_format_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == beam_lower_addr && !frozen
    |=> o_rdata == {$past(beam.vpos[7:0]), $past(beam.hpos[8:1])})
    else $error("lower beam read badly formatted");
  upper_frozen_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == beam_upper_addr && frozen
    |=> o_rdata == $past(hold_upper))
    else $error("upper read not frozen");
  lower_frozen_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == beam_lower_addr && frozen
    |=> o_rdata == $past(hold_lower))
    else $error("lower read not frozen");

  // capture arming and single capture per frame
  second_trig_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    frozen && !beam.vblank_exit |=> frozen && $stable(hold_upper))
    else $error("later trigger moved the capture");
  rearm_capture_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    beam.vblank_exit ##1
    (pen_edge && plane_ctl[pen_enable_bit] && !beam.vblank_exit)
    |=> frozen)
    else $error("capture not rearmed after blanking");
  plane_write_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_wr && i_addr == plane_ctl_addr |=> plane_ctl == $past(i_wdata))
    else $error("plane control write lost");

  // pot control register and pins
  pot_lock_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !(i_wr && i_addr == pot_write_addr) |=> $stable(pot_ctl))
    else $error("pot control changed without write");
  ident_bits_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == pot_read_addr |=> o_rdata[7:0] == ident_bits[7:0])
    else $error("identification bits wrong");
  pin_sense_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == pot_read_addr |=> o_rdata[8] == $past(pin_s[0]))
    else $error("pin level not returned");
  enable_drive_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    pot_ctl[1]
    |=> o_pot_oe[0] && o_pot_pin[0] == $past(pot_ctl[0]) && !o_pot_dump[0])
    else $error("enabled pin not driven");
  driven_hold_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    pot_ctl[3] && !pot_go |=> $stable(pot_cnt[1]))
    else $error("driven pin still counting");
  dump_input_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    dumping && !pot_ctl[7] |=> o_pot_dump[3])
    else $error("input pin not discharged");

  // pot counters
  go_dump_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    pot_go |=> dumping && reset_lines == 4'h0)
    else $error("start did not begin reset interval");
  count_step_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    beam.line_start && !dumping && !pot_done[2] && !pot_ctl[5]
    && !cmp_s[2] && !pot_go
    |=> pot_cnt[2] == $past(pot_cnt[2]) + 8'h01)
    else $error("count did not advance");
  count_hold_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    pot_done[3] && !pot_go |=> $stable(pot_cnt[3]))
    else $error("count moved after threshold");
  port_count_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_rd && i_addr == pot1_addr
    |=> o_rdata == {$past(pot_cnt[3]), $past(pot_cnt[2])})
    else $error("pot count read wrong");
endmodule

// ==== port_partner.sv ====
// controller port model: pen trigger, buttons and pot lines
`timescale 1ns/100ps
module port_partner #(
  parameter int p_settle = 500 // line settle time in ns
)(
  input wire logic [3:0] i_oe, // drive enable from block
  input wire logic [3:0] i_pin, // drive level from block
  input wire logic [3:0] i_dump, // discharge from block
  input wire logic [3:0] i_press, // buttons grounding lines
  input wire logic [3:0] i_above, // capacitor above threshold
  input wire logic i_trig, // pen sees the beam
  output logic [3:0] o_level, // line level seen by block
  output logic [3:0] o_cmp, // threshold compare
  output logic o_fire_n // trigger pin, low active
);
  logic [3:0] line;
  // pulled up when undriven; a button or a dump pulls it low
  always_comb begin
    line = (i_oe & i_pin | ~i_oe & ~i_dump) & ~i_press;
  end
  initial o_level = 4'hF;
  // heavy line capacitance makes changes slow
  always @(line) o_level <= #(p_settle) line;
  assign o_cmp = i_above & ~i_dump;
  assign o_fire_n = ~i_trig;
endmodule

// ==== lightpen_pot_port_tb_top.sv ====
// self-checking bench for the pen latch and pot port
`timescale 1ns/100ps
module lightpen_pot_port_tb_top;
  import lpen_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [23:0] i_addr = 24'h000000;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic fire_n, trig = 1'b0;
  logic [3:0] lvl, cmp, oe, pin, dump, press = 4'h0, above = 4'h0;
  int fails = 0, n_checks = 0, cyc = 0;
  localparam int line_c = 16;
  always #50 i_clk = ~i_clk;
  lightpen_pot_port #(.p_last_v(9'h01F), .p_last_h(9'h00F)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_fire_n(fire_n), .i_pot_pin(lvl), .i_pot_cmp(cmp),
    .o_pot_pin(pin), .o_pot_oe(oe), .o_pot_dump(dump));
  port_partner far (.i_oe(oe), .i_pin(pin), .i_dump(dump),
    .i_press(press), .i_above(above), .i_trig(trig),
    .o_level(lvl), .o_cmp(cmp), .o_fire_n(fire_n));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input logic [7:0] got, input int lo, input int hi);
    n_checks++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      fails++;
      $display("[ERR] %0t got %h out of %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // upper then lower with no gap, as one long word
  task automatic rd_long(output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= beam_upper_addr;
    @(posedge i_clk);
    i_addr <= beam_lower_addr;
    #1 d[31:16] = o_rdata;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d[15:0] = o_rdata;
  endtask
  task automatic t_regs();
    logic [15:0] d;
    rd(24'hDFF0FE, d);
    chk(d, 16'h0000);
    rd(pot_write_addr, d);
    chk(d, 16'h0000);
    $display("regs done");
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      wr(pot_write_addr, 16'h0300 << (2 * i));
      @(posedge i_clk);
      #1 chk({4'h0, oe, 4'h0, pin}, {4'h0, 4'h1 << i, 4'h0, 4'h1 << i});
      wr(pot_write_addr, 16'h0200 << (2 * i));
      @(posedge i_clk);
      #1 chk({4'h0, oe, 4'h0, pin}, {4'h0, 4'h1 << i, 8'h00});
    end
    wr(pot_write_addr, 16'h00FE);
    repeat (3) @(posedge i_clk);
    #1 chk({oe, pin, dump, 4'h0}, 16'h0000);
    $display("pins done");
  endtask
  task automatic t_button();
    logic [15:0] d;
    wr(pot_write_addr, 16'hFF00);
    repeat (10) @(posedge i_clk);
    rd(pot_read_addr, d);
    chk(d, 16'hFF00);
    press <= 4'h1;
    repeat (10) @(posedge i_clk);
    rd(pot_read_addr, d);
    chk(d, 16'hFE00);
    wr(pot_write_addr, 16'h0000);
    repeat (10) @(posedge i_clk);
    rd(pot_read_addr, d);
    chk(d, 16'h5400);
    press <= 4'h0;
    repeat (10) @(posedge i_clk);
    rd(pot_read_addr, d);
    chk(d, 16'h5500);
    $display("button done");
  endtask
  task automatic t_pots();
    logic [15:0] a, b;
    above <= 4'h3;
    wr(pot_write_addr, 16'h0001);
    @(posedge i_clk);
    #1 chk({12'h000, dump}, 16'h000F);
    repeat (5 * line_c) @(posedge i_clk);
    rd(pot1_addr, a);
    chk(a, 16'h0000);
    repeat (15 * line_c) @(posedge i_clk);
    rd(pot0_addr, a);
    chk(a, 16'h0000);
    rd(pot1_addr, a);
    chk_in(a[15:8], 10, 13);
    chk_in(a[7:0], 10, 13);
    above <= 4'hF;
    repeat (3 * line_c) @(posedge i_clk);
    rd(pot1_addr, a);
    repeat (3 * line_c) @(posedge i_clk);
    rd(pot1_addr, b);
    chk(b, a);
    $display("pots done");
  endtask
  task automatic t_pen();
    logic [31:0] a, b;
    int n;
    wr(plane_ctl_addr, 16'h0008);
    n = 0;
    do begin
      rd_long(a);
      n++;
    end while ({a[16], a[15:8]} !== 9'd25 && n < 600);
    trig <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd_long(a);
    chk_in(a[15:8], 25, 26);
    chk(a[31:16], 16'h0000);
    chk({15'h0000, a[16:0] < 17'h10500}, 16'h0001);
    repeat (2 * line_c) @(posedge i_clk);
    trig <= 1'b0;
    repeat (4) @(posedge i_clk);
    trig <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd_long(b);
    chk(b[31:16], a[31:16]);
    chk(b[15:0], a[15:0]);
    trig <= 1'b0;
    repeat (24 * line_c) @(posedge i_clk);
    rd_long(a);
    repeat (line_c) @(posedge i_clk);
    rd_long(b);
    chk({15'h0000, a !== b}, 16'h0001);
    trig <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd_long(a);
    repeat (line_c) @(posedge i_clk);
    rd_long(b);
    chk(b[15:0], a[15:0]);
    trig <= 1'b0;
    wr(plane_ctl_addr, 16'h0000);
    repeat (32 * line_c) @(posedge i_clk);
    trig <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd_long(a);
    repeat (line_c) @(posedge i_clk);
    rd_long(b);
    chk({15'h0000, a !== b}, 16'h0001);
    $display("pen done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_pins();
    t_button();
    t_pots();
    t_pen();
    stop_test();
  end
endmodule
